//--- src/sft_regs.svh
`ifndef SFT_REGS_SVH
`define SFT_REGS_SVH

// register indices; the byte address is four times the index
`define IDX_P1_DELAY 10'h002
`define IDX_P1_CODES 10'h004
`define IDX_P1_OPTS 10'h005
`define IDX_P2_DELAY 10'h00C
`define IDX_P2_CODES 10'h00E
`define IDX_P2_OPTS 10'h00F
`define IDX_ENABLED 10'h010
`define IDX_CC_BASE 10'h011
`define IDX_ERR_FLAGS 10'h019
`define IDX_P1_STATUS 10'h01A
`define IDX_P2_STATUS 10'h01B
`define IDX_CTRL0 10'h020
`define IDX_CTRL1 10'h021
`define IDX_COUNT 10'h022
`define IDX_CMD 10'h023
`define IDX_SRC_BASE 10'h080
`define SRC_WORDS 129
`define NUM_LPORTS 8

// reset values
`define RST_ENABLED 8'hFF
`define RST_CCODE 16'h0000
`define RST_TXD 2'h3

// field positions
`define DLY_EN_BIT 15
`define DLY_VAL_HI 14
`define CODE_START_HI 15
`define CODE_START_LO 8
`define CODE_END_HI 7
`define CODE_END_LO 0
`define OPT_START_HI 15
`define OPT_START_LO 12
`define OPT_END_HI 11
`define OPT_END_LO 8
`define C0_ORDER_HI 15
`define C0_ORDER_LO 12
`define C0_MODEM_HI 7
`define C0_MODEM_LO 4
`define C1_LPORT_HI 15
`define C1_LPORT_LO 12
`define C1_PHYS_HI 11
`define C1_PHYS_LO 8
`define C1_ADDR_HI 7
`define C1_ADDR_LO 0
`define EXEC_BIT 5
`define SRC_LINE_A_BIT 15
`define SRC_LINE_B_BIT 14

// field values and limits
`define MAX_COUNT 16'h0100
`define MAX_DELAY 15'h7530
`define LPORT_AUTO 4'hF
`define LPORT_LAST 4'h7
`define PHYS_LAST 4'h2
`define DIRECT_P1 8'h80
`define DIRECT_P2 8'h81
`define MODEM_NONE 4'h0
`define MODEM_SREQ 4'h1
`define MODEM_TRDY 4'h2
`define MODEM_BOTH 4'h3
`define ORDER_LAST 4'h1
`define START_LAST 4'h1
`define TRAIL_NONE 2'h0
`define TRAIL_CODE 2'h1
`define TRAIL_CRLF 2'h2
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A

// completion codes
`define CC_OK 16'h0000
`define CC_TOO_LONG 16'h1001
`define CC_TOO_SHORT 16'h1002
`define CC_COUNT_MISMATCH 16'h1003
`define CC_BAD_FORMAT 16'h1004
`define CC_PARAM 16'h110C
`define CC_BUSY 16'h2201
`define CC_SWITCHING 16'h2202
`define CC_TIMEOUT 16'h0205
`define CC_UNDEFINED 16'h0401

// timing
`define CLK_MHZ 200
`define DELAY_STEP_MS 10
`define DELAY_STEP_CYCLES (`DELAY_STEP_MS * 1000 * `CLK_MHZ)
`define BAUD_DIV 16'h06C8

`endif

//--- src/sft_pkg.sv
package sft_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic txd;
    logic send_request_line;
    logic terminal_ready_line;
  } serial_pins_t;

  typedef enum logic [1:0] {ENG_IDLE, ENG_DELAY, ENG_SEND, ENG_WAIT} eng_state_t;
  typedef enum logic [1:0] {PH_START, PH_DATA, PH_TRAIL} phase_t;

  typedef struct packed {
    logic busy;
    logic [8:0] frame;
    logic [3:0] bits;
    logic [15:0] div;
    logic txd;
  } shifter_state_t;

  typedef struct packed {
    logic [1:0][15:0] delay_cfg;
    logic [1:0][15:0] code_vals;
    logic [1:0][15:0] code_opts;
    logic [15:0] ctrl0;
    logic [15:0] ctrl1;
    logic [15:0] count;
    logic [7:0] enabled;
    logic [7:0] err_flags;
    logic [7:0][15:0] ccode;
    logic cmd_error;
    logic [7:0] src_top;
    logic [128:0][15:0] src;
    eng_state_t eng;
    phase_t phase;
    logic port_sel;
    logic [2:0] lport;
    logic start_en;
    logic [7:0] start_byte;
    logic [7:0] end_byte;
    logic [1:0] trail;
    logic trail_pos;
    logic lo_first;
    logic base;
    logic [8:0] pos;
    logic [8:0] plen;
    logic [14:0] delay_left;
    logic [23:0] tick;
    logic [1:0] exec;
    logic [1:0] sreq_line;
    logic [1:0] trdy_line;
    logic [1:0] txd_q;
    logic [31:0] prdata;
    logic pslverr;
  } sft_state_t;

endpackage

//--- src/byte_shifter.sv
`timescale 1ns/1ps
`include "sft_regs.svh"

module byte_shifter #(
  parameter logic [15:0] BAUD_DIV = `BAUD_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic in_ready,
  output logic txd
);
  import sft_pkg::*;

  shifter_state_t s;
  shifter_state_t next_s;

  // one start bit, eight data bits lsb first, one stop bit
  always_comb begin
    next_s = s;
    if (!s.busy) begin
      if (in_valid) begin
        next_s.busy = 1'b1;
        next_s.frame = {1'b1, in_byte};
        next_s.bits = 4'h0;
        next_s.div = 16'h0000;
        next_s.txd = 1'b0;
      end
    end else if (s.div == BAUD_DIV - 16'h0001) begin
      next_s.div = 16'h0000;
      if (s.bits == 4'h9) begin
        next_s.busy = 1'b0;
        next_s.txd = 1'b1;
      end else begin
        next_s.txd = s.frame[0];
        next_s.frame = {1'b1, s.frame[8:1]};
        next_s.bits = s.bits + 4'h1;
      end
    end else begin
      next_s.div = s.div + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{busy: 1'b0, frame: 9'h1FF, bits: 4'h0, div: 16'h0000, txd: 1'b1};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ready only between characters so the stop bit is never cut short
  assign in_ready = !s.busy;
  assign txd = s.txd;

endmodule

//--- src/serial_frame_transmitter.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "sft_regs.svh"
// Functional notes
// - byte count above 0100 hex sets error, refused
// - no free or disabled logical port sets error
// - bad control operand sets error, else cleared
// - delay word bit 15 enables send delay
// - delay bits 0-14, max 7530 hex, 10 ms
// - code word: start byte high, end low
// - option bits 12-15: 1 prefixes start byte
// - option bits 8-11: end byte or CR LF
// - codes wrap payload, payload at most 256
// - frame at most 259 bytes long
// - second control word: address, port, logical port
// - logical port F picks a free port
// - port 0 uses unit address directly
// - modem lines driven from first source word
// - payload byte order from control word
// - executing flag bit 5 while sending
// - enabled flag low while operation runs
// - completion code 00 while running, then result
// - port error flag set on error end
// - command fault completion codes
// - busy, switching, timeout, undefined codes; only the busy code is ever reported here
// - send delay holds off transmission start
// - zero count sends nothing

module serial_frame_transmitter #(
  parameter int unsigned DELAY_STEP_CYCLES = `DELAY_STEP_CYCLES,
  parameter logic [15:0] BAUD_DIV = `BAUD_DIV,
  parameter logic [3:0] UNIT_NUMBER = 4'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire sft_pkg::apb_req_t apb_in,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output sft_pkg::serial_pins_t [1:0] serial_pins
);
  import sft_pkg::*;

  sft_state_t s;
  sft_state_t next_s;
  logic tx_valid;
  logic [7:0] tx_byte;
  logic tx_ready;
  logic sh_txd;

  byte_shifter #(.BAUD_DIV(BAUD_DIV)) shifter (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(tx_valid),
    .in_byte(tx_byte),
    .in_ready(tx_ready),
    .txd(sh_txd)
  );

  // byte under the sequencer; the payload may start one word in
  logic [7:0] word_idx;
  logic [15:0] cur_word;
  always_comb begin
    word_idx = s.pos[8:1] + {7'h00, s.base};
    cur_word = s.src[word_idx];
    tx_byte = 8'h00;
    case (s.phase)
      PH_START: tx_byte = s.start_byte;
      PH_DATA: tx_byte = (s.pos[0] ^ s.lo_first) ? cur_word[7:0] : cur_word[15:8];
      default: begin
        if (s.trail == `TRAIL_CODE) begin
          tx_byte = s.end_byte;
        end else begin
          tx_byte = s.trail_pos ? `CHAR_LF : `CHAR_CR;
        end
      end
    endcase
  end
  assign tx_valid = (s.eng == ENG_SEND);

  // apb decode, operation start and frame sequencing
  logic acc;
  logic setup;
  logic [9:0] idx;
  logic [31:0] rdata;
  logic mapped;
  logic start_cmd;
  logic [3:0] c_lp;
  logic [3:0] c_phys;
  logic [7:0] c_addr;
  logic [3:0] c_modem;
  logic [3:0] c_order;
  logic c_bad;
  logic lp_ok;
  logic free_any;
  logic [2:0] free_lp;
  logic [2:0] lp;
  logic pnum;
  logic [15:0] code;
  logic [15:0] dcfg;
  logic [15:0] opts;
  logic [9:0] words_needed;
  logic [15:0] srcw;
  always_comb begin
    next_s = s;
    acc = apb_in.psel && apb_in.penable;
    setup = apb_in.psel && !apb_in.penable;
    idx = apb_in.paddr[11:2];
    rdata = 32'h00000000;
    mapped = 1'b1;
    start_cmd = 1'b0;
    c_lp = s.ctrl1[`C1_LPORT_HI:`C1_LPORT_LO];
    c_phys = s.ctrl1[`C1_PHYS_HI:`C1_PHYS_LO];
    c_addr = s.ctrl1[`C1_ADDR_HI:`C1_ADDR_LO];
    c_modem = s.ctrl0[`C0_MODEM_HI:`C0_MODEM_LO];
    c_order = s.ctrl0[`C0_ORDER_HI:`C0_ORDER_LO];
    code = `CC_OK;
    pnum = 1'b0;
    lp = 3'h0;
    dcfg = 16'h0000;
    opts = 16'h0000;
    srcw = 16'h0000;
    words_needed = 10'h000;
    // lowest enabled logical port for automatic choice
    free_any = |s.enabled;
    free_lp = 3'h0;
    for (int i = `NUM_LPORTS - 1; i >= 0; i--) begin
      if (s.enabled[i]) begin
        free_lp = 3'(i);
      end
    end

    // read data and error are captured in setup, shown in access
    if (idx == `IDX_P1_DELAY) begin
      rdata = {16'h0000, s.delay_cfg[0]};
    end else if (idx == `IDX_P1_CODES) begin
      rdata = {16'h0000, s.code_vals[0]};
    end else if (idx == `IDX_P1_OPTS) begin
      rdata = {16'h0000, s.code_opts[0]};
    end else if (idx == `IDX_P2_DELAY) begin
      rdata = {16'h0000, s.delay_cfg[1]};
    end else if (idx == `IDX_P2_CODES) begin
      rdata = {16'h0000, s.code_vals[1]};
    end else if (idx == `IDX_P2_OPTS) begin
      rdata = {16'h0000, s.code_opts[1]};
    end else if (idx == `IDX_ENABLED) begin
      rdata = {24'h000000, s.enabled};
    end else if (idx >= `IDX_CC_BASE && idx < `IDX_CC_BASE + 10'h008) begin
      rdata = {16'h0000, s.ccode[3'(idx - `IDX_CC_BASE)]};
    end else if (idx == `IDX_ERR_FLAGS) begin
      rdata = {24'h000000, s.err_flags};
    end else if (idx == `IDX_P1_STATUS) begin
      rdata = {26'h0000000, s.exec[0], 5'h00};
    end else if (idx == `IDX_P2_STATUS) begin
      rdata = {26'h0000000, s.exec[1], 5'h00};
    end else if (idx == `IDX_CTRL0) begin
      rdata = {16'h0000, s.ctrl0};
    end else if (idx == `IDX_CTRL1) begin
      rdata = {16'h0000, s.ctrl1};
    end else if (idx == `IDX_COUNT) begin
      rdata = {16'h0000, s.count};
    end else if (idx == `IDX_CMD) begin
      rdata = {30'h00000000, s.eng != ENG_IDLE, s.cmd_error};
    end else if (idx >= `IDX_SRC_BASE && idx < `IDX_SRC_BASE + 10'(`SRC_WORDS)) begin
      rdata = {16'h0000, s.src[8'(idx - `IDX_SRC_BASE)]};
    end else begin
      mapped = 1'b0;
    end
    if (apb_in.paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end
    if (setup) begin
      next_s.prdata = apb_in.pwrite ? 32'h00000000 : rdata;
      next_s.pslverr = !mapped;
    end

    // writes land in the access cycle; status words ignore them
    if (acc && apb_in.pwrite && mapped) begin
      if (idx == `IDX_P1_DELAY) begin
        next_s.delay_cfg[0] = apb_in.pwdata[15:0];
      end else if (idx == `IDX_P1_CODES) begin
        next_s.code_vals[0] = apb_in.pwdata[15:0];
      end else if (idx == `IDX_P1_OPTS) begin
        next_s.code_opts[0] = apb_in.pwdata[15:0];
      end else if (idx == `IDX_P2_DELAY) begin
        next_s.delay_cfg[1] = apb_in.pwdata[15:0];
      end else if (idx == `IDX_P2_CODES) begin
        next_s.code_vals[1] = apb_in.pwdata[15:0];
      end else if (idx == `IDX_P2_OPTS) begin
        next_s.code_opts[1] = apb_in.pwdata[15:0];
      end else if (idx == `IDX_CTRL0) begin
        next_s.ctrl0 = apb_in.pwdata[15:0];
      end else if (idx == `IDX_CTRL1) begin
        next_s.ctrl1 = apb_in.pwdata[15:0];
      end else if (idx == `IDX_COUNT) begin
        next_s.count = apb_in.pwdata[15:0];
      end else if (idx == `IDX_CMD) begin
        start_cmd = apb_in.pwdata[0];
      end else if (idx >= `IDX_SRC_BASE) begin
        next_s.src[8'(idx - `IDX_SRC_BASE)] = apb_in.pwdata[15:0];
        if (8'(idx - `IDX_SRC_BASE) >= s.src_top) begin
          next_s.src_top = 8'(idx - `IDX_SRC_BASE) + 8'h01;
        end
      end
    end

    // start: operand checks first, then the port is claimed
    c_bad = (c_modem > `MODEM_BOTH) || (c_order > `ORDER_LAST) || (c_phys > `PHYS_LAST)
      || (c_lp > `LPORT_LAST && c_lp != `LPORT_AUTO);
    lp_ok = (c_lp == `LPORT_AUTO) ? free_any : s.enabled[c_lp[2:0]];
    if (start_cmd) begin
      if (s.count > `MAX_COUNT || c_bad || !lp_ok) begin
        next_s.cmd_error = 1'b1;
      end else begin
        next_s.cmd_error = 1'b0;
        lp = (c_lp == `LPORT_AUTO) ? free_lp : c_lp[2:0];
        next_s.err_flags[lp] = 1'b0;
        next_s.ccode[lp] = `CC_OK;
        // port 0 means the address names the serial port itself
        if (c_phys == 4'h0) begin
          if (c_addr == `DIRECT_P1 + {2'b00, UNIT_NUMBER, 2'b00}) begin
            pnum = 1'b0;
          end else if (c_addr == `DIRECT_P2 + {2'b00, UNIT_NUMBER, 2'b00}) begin
            pnum = 1'b1;
          end else begin
            code = `CC_PARAM;
          end
        end else begin
          pnum = (c_phys == 4'h2);
        end
        dcfg = s.delay_cfg[pnum];
        opts = s.code_opts[pnum];
        words_needed = ((10'({1'b0, s.count[8:0]}) + 10'h001) >> 1) + {9'h000, c_modem != `MODEM_NONE};
        if (opts[`OPT_START_HI:`OPT_START_LO] > `START_LAST || opts[`OPT_END_HI:`OPT_END_LO] > 4'h2
          || (dcfg[`DLY_EN_BIT] && dcfg[`DLY_VAL_HI:0] > `MAX_DELAY)) begin
          code = `CC_PARAM;
        end else if (words_needed > {2'b00, s.src_top}) begin
          code = `CC_COUNT_MISMATCH;
        end
        if (s.eng != ENG_IDLE) begin
          code = `CC_BUSY;
        end
        if (code != `CC_OK) begin
          next_s.ccode[lp] = code;
          next_s.err_flags[lp] = 1'b1;
        end else begin
          // modem lines follow the top bits of the first source word
          srcw = s.src[0];
          if (c_modem == `MODEM_SREQ) begin
            next_s.sreq_line[pnum] = srcw[`SRC_LINE_A_BIT];
          end else if (c_modem == `MODEM_TRDY) begin
            next_s.trdy_line[pnum] = srcw[`SRC_LINE_A_BIT];
          end else if (c_modem == `MODEM_BOTH) begin
            next_s.sreq_line[pnum] = srcw[`SRC_LINE_A_BIT];
            next_s.trdy_line[pnum] = srcw[`SRC_LINE_B_BIT];
          end
          if (s.count != 16'h0000) begin
            next_s.enabled[lp] = 1'b0;
            next_s.exec[pnum] = 1'b1;
            next_s.lport = lp;
            next_s.port_sel = pnum;
            next_s.start_byte = s.code_vals[pnum][`CODE_START_HI:`CODE_START_LO];
            next_s.end_byte = s.code_vals[pnum][`CODE_END_HI:`CODE_END_LO];
            next_s.start_en = opts[`OPT_START_LO];
            next_s.trail = opts[`OPT_END_LO + 1:`OPT_END_LO];
            next_s.lo_first = c_order[0];
            next_s.base = (c_modem != `MODEM_NONE);
            next_s.plen = s.count[8:0];
            next_s.pos = 9'h000;
            next_s.trail_pos = 1'b0;
            next_s.phase = opts[`OPT_START_LO] ? PH_START : PH_DATA;
            next_s.delay_left = dcfg[`DLY_VAL_HI:0];
            next_s.tick = 24'h000000;
            next_s.eng = dcfg[`DLY_EN_BIT] ? ENG_DELAY : ENG_SEND;
          end
          // a zero count ends at once with nothing on the line
        end
      end
    end

    // send delay counts 10 ms steps before the first character
    case (s.eng)
      ENG_DELAY: begin
        if (s.delay_left == 15'h0000) begin
          next_s.eng = ENG_SEND;
        end else if (s.tick == 24'(DELAY_STEP_CYCLES - 1)) begin
          next_s.tick = 24'h000000;
          next_s.delay_left = s.delay_left - 15'h0001;
        end else begin
          next_s.tick = s.tick + 24'h000001;
        end
      end
      ENG_SEND: begin
        // start code, payload, trailer: at most 1 + 256 + 2 characters
        if (tx_ready) begin
          case (s.phase)
            PH_START: next_s.phase = PH_DATA;
            PH_DATA: begin
              if (s.pos == s.plen - 9'h001) begin
                if (s.trail == `TRAIL_NONE) begin
                  next_s.eng = ENG_WAIT;
                end else begin
                  next_s.phase = PH_TRAIL;
                end
              end else begin
                next_s.pos = s.pos + 9'h001;
              end
            end
            default: begin
              if (s.trail == `TRAIL_CRLF && !s.trail_pos) begin
                next_s.trail_pos = 1'b1;
              end else begin
                next_s.eng = ENG_WAIT;
              end
            end
          endcase
        end
      end
      ENG_WAIT: begin
        // last stop bit out: release the port with a normal end
        if (tx_ready) begin
          next_s.eng = ENG_IDLE;
          next_s.enabled[s.lport] = 1'b1;
          next_s.exec[s.port_sel] = 1'b0;
          next_s.ccode[s.lport] = `CC_OK;
        end
      end
      default: begin
      end
    endcase

    // idle lines sit at mark; only the active port carries the shifter
    for (int p = 0; p < 2; p++) begin
      next_s.txd_q[p] = (s.eng != ENG_IDLE && s.port_sel == 1'(p)) ? sh_txd : 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.enabled <= `RST_ENABLED;
      s.ccode <= {`NUM_LPORTS{`RST_CCODE}};
      s.eng <= ENG_IDLE;
      s.phase <= PH_START;
      s.txd_q <= `RST_TXD;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // zero wait state slave; ce low stretches the access
  assign pready = ce;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_pins
      assign serial_pins[g].txd = s.txd_q[g];
      assign serial_pins[g].send_request_line = s.sreq_line[g];
      assign serial_pins[g].terminal_ready_line = s.trdy_line[g];
    end
  endgenerate

endmodule

//--- verification/sft_chk.sv
`timescale 1ns/1ps
`include "sft_regs.svh"
module sft_chk #(
  parameter logic [15:0] BAUD_DIV = 16'h0004
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire sft_pkg::apb_req_t apb_in,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sft_pkg::serial_pins_t [1:0] serial_pins
);
  import sft_pkg::*;
  localparam int BD = int'(BAUD_DIV);
  logic acc;
  int fr_cnt;

  assign acc = apb_in.psel && apb_in.penable && pready;

  // position inside the character on port 1; only valid while ce stays high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_cnt <= 0;
    end else if (fr_cnt == 0) begin
      fr_cnt <= serial_pins[0].txd ? 0 : 1;
    end else begin
      fr_cnt <= (fr_cnt == 10 * BD - 1) ? 0 : fr_cnt + 1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_pready_ce: assert property (pready == ce) else $error("pready differs from ce");
  chk_misalign_err: assert property (acc && apb_in.paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access without error");
  chk_upper_zero: assert property (acc && !apb_in.pwrite && !pslverr |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_answer_stands: assert property (acc |=> $stable(prdata) && $stable(pslverr))
    else $error("answer changed before next setup");
  chk_reset_idle: assert property ($rose(presetn) |-> serial_pins[0].txd && serial_pins[1].txd)
    else $error("line not idle after reset");
  chk_start_bit: assert property (fr_cnt > 0 && fr_cnt < BD |-> !serial_pins[0].txd)
    else $error("start bit too short");
  chk_stop_bit: assert property (fr_cnt >= 9 * BD |-> serial_pins[0].txd)
    else $error("stop bit missing");
  chk_exec_wire: assert property (acc && !apb_in.pwrite && apb_in.paddr[11:2] == `IDX_P1_STATUS
    && fr_cnt > 1 && fr_cnt < 8 * BD |-> prdata[5]) else $error("executing flag low while sending");
endmodule

bind serial_frame_transmitter sft_chk #(.BAUD_DIV(BAUD_DIV)) sft_chk_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .apb_in(apb_in), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_pins(serial_pins));

//--- verification/serial_printer_model.sv
`timescale 1ns/1ps
module serial_printer_model #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic pclk,
  input wire logic txd
);
  logic [7:0] rx_q[$];
  int frame_errs = 0;

  // samples mid-bit; a printer only listens, so nothing is driven back
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge pclk);
        b[i] = txd; // lsb first, raw character
      end
      repeat (BIT_CYCLES) @(posedge pclk);
      if (txd !== 1'b1) frame_errs++;
      rx_q.push_back(b);
    end
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
`include "sft_regs.svh"
module tb;
  import sft_pkg::*;
  localparam int STEP = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  apb_req_t apb_in = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  serial_pins_t [1:0] serial_pins;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] exp_q[$];

  serial_frame_transmitter #(.DELAY_STEP_CYCLES(STEP), .BAUD_DIV(16'h0004), .UNIT_NUMBER(4'h0))
    serial_frame_transmitter_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_in(apb_in),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_pins(serial_pins));
  serial_printer_model #(.BIT_CYCLES(4)) printer1 (.pclk(pclk), .txd(serial_pins[0].txd));
  serial_printer_model #(.BIT_CYCLES(4)) printer2 (.pclk(pclk), .txd(serial_pins[1].txd));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // request held until pready is sampled high
  task automatic apb(logic wr_en, logic [11:0] addr, logic [15:0] wd);
    @(posedge pclk);
    apb_in <= '{1'b1, 1'b0, wr_en, addr, {16'h0000, wd}};
    @(posedge pclk);
    apb_in.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask

  task automatic wr(logic [9:0] idx, logic [15:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask

  task automatic rdc(string what, logic [9:0] idx, logic [31:0] expv);
    apb(1'b0, {idx, 2'b00}, 16'h0000);
    check(what, rd, expv);
  endtask

  task automatic go(logic [15:0] c0, logic [15:0] c1, logic [15:0] n);
    wr(`IDX_CTRL0, c0);
    wr(`IDX_CTRL1, c1);
    wr(`IDX_COUNT, n);
    wr(`IDX_CMD, 16'h0001);
  endtask

  // the two ports' register sets sit ten words apart
  task automatic cfg(int p, logic [15:0] dly, logic [15:0] codes, logic [15:0] opts);
    wr(10'(`IDX_P1_DELAY + 10 * p), dly);
    wr(10'(`IDX_P1_CODES + 10 * p), codes);
    wr(10'(`IDX_P1_OPTS + 10 * p), opts);
  endtask

  // waits out the port, then compares what the printer got
  task automatic rx_chk(int p);
    logic [7:0] q[$];
    do apb(1'b0, {10'(`IDX_P1_STATUS + p), 2'b00}, 16'h0000); while (rd[5] !== 1'b0);
    repeat (8) @(posedge pclk); // margin only; the printer sampled the stop bit before the flag fell
    if (p == 0) q = printer1.rx_q;
    else q = printer2.rx_q;
    check("rx count", q.size(), exp_q.size());
    foreach (exp_q[i]) check("rx byte", {24'h0, q[i]}, {24'h0, exp_q[i]});
    check("frame errs", printer1.frame_errs + printer2.frame_errs, 32'h0);
    printer1.rx_q.delete();
    printer2.rx_q.delete();
    exp_q.delete();
  endtask

  task automatic t_regs();
    rdc("enabled", `IDX_ENABLED, 32'h000000FF);
    for (int i = 0; i < 8; i++) rdc("ccode", 10'(`IDX_CC_BASE + i), 32'h0);
    rdc("err flags", `IDX_ERR_FLAGS, 32'h0);
    wr(`IDX_P2_CODES, 16'hC3A5);
    rdc("codes", `IDX_P2_CODES, 32'h0000C3A5);
    apb(1'b0, 12'h009, 16'h0000);
    check("misaligned", {31'h0, err}, 32'h1);
    apb(1'b1, 12'hFF0, 16'h1234);
    check("unmapped", {31'h0, err}, 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    check("pready", {31'h0, pready}, 32'h0);
    ce <= 1'b1;
  endtask

  // refusals and error ends, before any source word exists
  task automatic t_errs();
    go(16'h0000, 16'h0100, 16'h0002);
    rx_chk(0);
    rdc("cc no data", `IDX_CC_BASE, {16'h0, `CC_COUNT_MISMATCH});
    go(16'h0000, 16'h0100, 16'h0101);
    rdc("count over", `IDX_CMD, 32'h1);
    go(16'h0000, 16'h9100, 16'h0000);
    rdc("bad lport", `IDX_CMD, 32'h1);
    go(16'h0000, 16'h5084, 16'h0000);
    rdc("direct bad", 10'(`IDX_CC_BASE + 5), {16'h0, `CC_PARAM});
    go(16'h0000, 16'h6080, 16'h0000);
    rdc("direct ok", `IDX_CMD, 32'h0);
    go(16'h0000, 16'h6081, 16'h0000);
    rdc("direct p2", 10'(`IDX_CC_BASE + 6), 32'h0);
    rdc("err flags", `IDX_ERR_FLAGS, 32'h21);
    rdc("enabled", `IDX_ENABLED, 32'h000000FF);
  endtask

  // longest frame, with a busy port and a busy engine meanwhile
  task automatic t_long();
    for (int k = 0; k < 128; k++) wr(10'(`IDX_SRC_BASE + k), {8'(k), ~8'(k)});
    cfg(0, 16'h0000, 16'h5A00, 16'h1200);
    exp_q.push_back(8'h5A);
    for (int k = 0; k < 128; k++) begin
      exp_q.push_back(8'(k));
      exp_q.push_back(~8'(k));
    end
    exp_q.push_back(`CHAR_CR);
    exp_q.push_back(`CHAR_LF);
    go(16'h0000, 16'h1100, 16'h0100);
    rdc("enabled busy", `IDX_ENABLED, 32'h000000FD);
    rdc("cc busy", 10'(`IDX_CC_BASE + 1), 32'h0);
    go(16'h0000, 16'h1100, 16'h0001);
    rdc("port taken", `IDX_CMD, 32'h3);
    go(16'h0000, 16'hF100, 16'h0001);
    rdc("auto busy", `IDX_CC_BASE, {16'h0, `CC_BUSY});
    rx_chk(0);
  endtask

  // line selections; zero counts leave the wire quiet
  task automatic t_modem();
    cfg(0, 16'h0000, 16'h0000, 16'h0000);
    wr(`IDX_SRC_BASE, 16'h8000);
    go(16'h0010, 16'h0100, 16'h0000);
    go(16'h0020, 16'h0100, 16'h0000);
    rx_chk(0);
    check("sreq", {31'h0, serial_pins[0].send_request_line}, 32'h1);
    check("trdy", {31'h0, serial_pins[0].terminal_ready_line}, 32'h1);
    wr(`IDX_SRC_BASE, 16'h4000);
    wr(10'(`IDX_SRC_BASE + 1), 16'hABCD);
    wr(10'(`IDX_SRC_BASE + 2), 16'hEF12);
    exp_q = '{8'hAB, 8'hCD, 8'hEF};
    go(16'h0030, 16'h0100, 16'h0003);
    rx_chk(0);
    check("sreq both", {31'h0, serial_pins[0].send_request_line}, 32'h0);
    check("trdy both", {31'h0, serial_pins[0].terminal_ready_line}, 32'h1);
    rdc("err cleared", `IDX_ERR_FLAGS, 32'h20);
  endtask

  // port 2, low byte first, end code, cycles until the start bit
  task automatic timed(logic [15:0] dly, int lo, int hi);
    int cyc;
    cyc = 0;
    cfg(1, dly, 16'h007E, 16'h0100);
    wr(`IDX_SRC_BASE, 16'h8000);
    wr(10'(`IDX_SRC_BASE + 1), 16'hABCD);
    exp_q = '{8'hCD, 8'hAB, 8'h7E};
    go(16'h1010, 16'h0200, 16'h0002);
    while (serial_pins[1].txd === 1'b1 && cyc < 400) begin
      @(posedge pclk);
      cyc++;
    end
    check("delay", {31'h0, cyc >= lo && cyc <= hi}, 32'h1);
    rx_chk(1);
    check("p2 sreq", {30'h0, serial_pins[1].send_request_line, serial_pins[0].send_request_line}, 32'h2);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_errs();
    t_long();
    t_modem();
    timed(16'h0002, 0, 8);
    timed(16'h8002, 2 * STEP, 2 * STEP + 10);
    cfg(1, 16'hF531, 16'h007E, 16'h0100);
    go(16'h1000, 16'hF200, 16'h0002);
    rdc("delay range", `IDX_CC_BASE, {16'h0, `CC_PARAM});
    final_report();
  end

  // watchdog: the run needs about 12k cycles
  initial begin
    #250000;
    n_mismatch++;
    final_report();
  end
endmodule
